/* rtl/dpd_dividers.sv */
// reference and feedback dividers with classic wishbone register slave
`timescale 1ns/10ps
module dpd_dividers
    import dpd_pkg::*;
#(
    parameter int RATIO_WIDTH = 16 // divider ratio width
) (
    input wire logic clk, // 250 MHz system clock
    input wire logic resetn, // synchronous reset, active low
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_we_i, // write enable
    input wire logic [11:0] wb_adr_i, // byte address
    input wire logic [3:0] wb_sel_i, // byte lane selects
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o, // transfer acknowledge
    input wire logic referenceInputA, // reference clock pin a
    input wire logic referenceInputB, // reference clock pin b
    input wire logic feedbackClockInput, // feedback clock pin
    output logic refDivPulse, // one cycle per reference period
    output logic fbDivPulse // one cycle per feedback period
);

    logic [7:0] refLow_q, refLow_d;
    logic [7:0] refHigh_q, refHigh_d;
    logic [7:0] refCtrl_q, refCtrl_d;
    logic [7:0] fbLow_q, fbLow_d;
    logic [7:0] fbHigh_q, fbHigh_d;
    logic [7:0] fbCtrl_q, fbCtrl_d;
    logic refSel_q, refSel_d;
    logic refSeen_q, refSeen_d;
    logic fbSeen_q, fbSeen_d;
    logic ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic [9:0] index;
    logic request;
    logic writeNow;
    logic [7:0] readByte;
    logic refEdge;
    logic fbEdge;
    logic refPulse;
    logic fbPulse;

    // register map lookup used only to zero the captured read data of unmapped words
    function automatic logic isMapped(input logic [9:0] idx);
        isMapped = (idx == REG_REF_DIVIDER_LOW) || (idx == REG_REF_DIVIDER_HIGH)
            || (idx == REG_REF_DIVIDER_CONTROL) || (idx == REG_FEEDBACK_DIVIDER_LOW)
            || (idx == REG_FEEDBACK_DIVIDER_HIGH) || (idx == REG_FEEDBACK_DIVIDER_CONTROL)
            || (idx == REG_INPUT_SELECT_STATUS);
    endfunction

    // bus decode; the two low byte address bits are ignored
    assign index = wb_adr_i[11:2];
    assign request = wb_cyc_i & wb_stb_i;
    assign writeNow = request & ack_q & wb_we_i & wb_sel_i[0];

    // read mux; reserved bits and unmapped words read as zero
    always_comb begin
        readByte = 8'h00;
        unique case (index)
            REG_REF_DIVIDER_LOW: readByte = refLow_q;
            REG_REF_DIVIDER_HIGH: readByte = refHigh_q;
            REG_REF_DIVIDER_CONTROL: readByte = refCtrl_q;
            REG_FEEDBACK_DIVIDER_LOW: readByte = fbLow_q;
            REG_FEEDBACK_DIVIDER_HIGH: readByte = fbHigh_q;
            REG_FEEDBACK_DIVIDER_CONTROL: readByte = fbCtrl_q;
            REG_INPUT_SELECT_STATUS: begin
                readByte[SEL_REF_B_BIT] = refSel_q;
                readByte[STAT_REF_PULSE_BIT] = refSeen_q;
                readByte[STAT_FB_PULSE_BIT] = fbSeen_q;
            end
            default: readByte = 8'h00;
        endcase
    end

    // ack one cycle after the request, dropped the cycle after; unmapped words ack too
    always_comb begin
        ack_d = request & ~ack_q;
        rdat_d = rdat_q;
        if (request & ~ack_q) begin
            rdat_d = isMapped(index) ? {24'h000000, readByte} : 32'h00000000;
        end
    end

    // register writes take effect at the edge where ack is seen high
    always_comb begin
        refLow_d = refLow_q;
        refHigh_d = refHigh_q;
        refCtrl_d = refCtrl_q;
        fbLow_d = fbLow_q;
        fbHigh_d = fbHigh_q;
        fbCtrl_d = fbCtrl_q;
        refSel_d = refSel_q;
        if (writeNow) begin
            unique case (index)
                REG_REF_DIVIDER_LOW: refLow_d = wb_dat_i[7:0];
                REG_REF_DIVIDER_HIGH: refHigh_d = wb_dat_i[7:0];
                REG_REF_DIVIDER_CONTROL: refCtrl_d = wb_dat_i[7:0] & CONTROL_MASK;
                REG_FEEDBACK_DIVIDER_LOW: fbLow_d = wb_dat_i[7:0];
                REG_FEEDBACK_DIVIDER_HIGH: fbHigh_d = wb_dat_i[7:0];
                REG_FEEDBACK_DIVIDER_CONTROL: fbCtrl_d = wb_dat_i[7:0] & CONTROL_MASK;
                REG_INPUT_SELECT_STATUS: refSel_d = wb_dat_i[SEL_REF_B_BIT];
                default: refSel_d = refSel_q;
            endcase
        end
    end

    // sticky activity flags, cleared at the edge that captures the read data, so a
    // pulse arriving between capture and ack is never lost; a pulse in that cycle wins
    always_comb begin
        refSeen_d = refSeen_q;
        fbSeen_d = fbSeen_q;
        if (request & ~ack_q & ~wb_we_i & (index == REG_INPUT_SELECT_STATUS)) begin
            refSeen_d = 1'b0;
            fbSeen_d = 1'b0;
        end
        if (refPulse) begin
            refSeen_d = 1'b1;
        end
        if (fbPulse) begin
            fbSeen_d = 1'b1;
        end
    end

    // all register state
    always_ff @(posedge clk) begin
        if (!resetn) begin
            refLow_q <= RESET_RATIO_BYTE;
            refHigh_q <= RESET_RATIO_BYTE;
            refCtrl_q <= RESET_CONTROL;
            fbLow_q <= RESET_RATIO_BYTE;
            fbHigh_q <= RESET_RATIO_BYTE;
            fbCtrl_q <= RESET_CONTROL;
            refSel_q <= RESET_REF_SELECT;
            refSeen_q <= 1'b0;
            fbSeen_q <= 1'b0;
            ack_q <= 1'b0;
            rdat_q <= 32'h00000000;
        end else begin
            refLow_q <= refLow_d;
            refHigh_q <= refHigh_d;
            refCtrl_q <= refCtrl_d;
            fbLow_q <= fbLow_d;
            fbHigh_q <= fbHigh_d;
            fbCtrl_q <= fbCtrl_d;
            refSel_q <= refSel_d;
            refSeen_q <= refSeen_d;
            fbSeen_q <= fbSeen_d;
            ack_q <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // reference path; pins are sampled at 250 MHz, so inputs must stay below 125 MHz
    dpd_edge_sel refEdgeSel (
        .clk(clk),
        .resetn(resetn),
        .pinIn({referenceInputB, referenceInputA}),
        .pinSel(refSel_q),
        .invert(refCtrl_q[CTRL_INVERT_BIT]),
        .prescale(refCtrl_q[CTRL_PRESCALE_BIT]),
        .edgePulse(refEdge)
    );

    dpd_ratio_div #(
        .WIDTH(RATIO_WIDTH)
    ) refDiv (
        .clk(clk),
        .resetn(resetn),
        .edgeIn(refEdge),
        .ratio(RATIO_WIDTH'({refHigh_q, refLow_q})),
        .divPulse(refPulse)
    );

    // feedback path has one pin, so the second synchroniser input is idle
    dpd_edge_sel fbEdgeSel (
        .clk(clk),
        .resetn(resetn),
        .pinIn({1'b0, feedbackClockInput}),
        .pinSel(1'b0),
        .invert(fbCtrl_q[CTRL_INVERT_BIT]),
        .prescale(fbCtrl_q[CTRL_PRESCALE_BIT]),
        .edgePulse(fbEdge)
    );

    dpd_ratio_div #(
        .WIDTH(RATIO_WIDTH)
    ) fbDiv (
        .clk(clk),
        .resetn(resetn),
        .edgeIn(fbEdge),
        .ratio(RATIO_WIDTH'({fbHigh_q, fbLow_q})),
        .divPulse(fbPulse)
    );

    assign refDivPulse = refPulse;
    assign fbDivPulse = fbPulse;

endmodule

/* rtl/dpd_pkg.sv */
// constants and register map of the reference and feedback divider block
//
// Summary of operation
// - reference divider divides its selected input by programmed value plus one.
// - reference ratio low byte at 0x0101, high byte bits 15:8 at 0x0102.
// - reference ratio bytes both zero give a divide ratio of exactly one.
// - reference control bit 7 inverts the input, counting falling edges.
// - reference control bit 0 adds a divide-by-2 prescaler to the reference path.
// - feedback divider divides its input by programmed value plus one.
// - feedback ratio low byte at 0x0104, high byte bits 15:8 at 0x0105.
// - feedback ratio bytes both zero give a divide ratio of one.
// - feedback control bit 0 adds a divide-by-2 prescaler before the feedback divider.
// - feedback control bit 7 inverts the feedback input, counting falling edges.
package dpd_pkg;

    // register indices; byte address on the bus is four times the index
    localparam logic [9:0] REG_REF_DIVIDER_LOW = 10'h101;
    localparam logic [9:0] REG_REF_DIVIDER_HIGH = 10'h102;
    localparam logic [9:0] REG_REF_DIVIDER_CONTROL = 10'h103;
    localparam logic [9:0] REG_FEEDBACK_DIVIDER_LOW = 10'h104;
    localparam logic [9:0] REG_FEEDBACK_DIVIDER_HIGH = 10'h105;
    localparam logic [9:0] REG_FEEDBACK_DIVIDER_CONTROL = 10'h106;
    localparam logic [9:0] REG_INPUT_SELECT_STATUS = 10'h130;

    // field positions
    localparam int CTRL_INVERT_BIT = 7;
    localparam int CTRL_PRESCALE_BIT = 0;
    localparam int SEL_REF_B_BIT = 0;
    localparam int STAT_REF_PULSE_BIT = 4;
    localparam int STAT_FB_PULSE_BIT = 5;

    // values after reset
    localparam logic [7:0] RESET_RATIO_BYTE = 8'h00;
    localparam logic [7:0] RESET_CONTROL = 8'h00;
    localparam logic RESET_REF_SELECT = 1'b0;

    // writable bits of the control registers; bits 6:1 are reserved and read zero
    localparam logic [7:0] CONTROL_MASK = 8'h81;

    // bus answer latency in cycles from request seen to ack
    localparam int BUS_ACK_CYCLES = 1;

endpackage

/* rtl/dpd_edge_sel.sv */
// input synchroniser, edge selection and optional divide-by-2 prescaler
`timescale 1ns/10ps
module dpd_edge_sel
    import dpd_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic resetn, // synchronous reset, active low
    input wire logic [1:0] pinIn, // raw clock pins from outside
    input wire logic pinSel, // chooses pinIn[1] when high
    input wire logic invert, // count falling edges instead of rising
    input wire logic prescale, // pass only every second edge
    output logic edgePulse // one cycle per counted edge
);

    logic [1:0] syncA_q, syncA_d;
    logic [1:0] syncB_q, syncB_d;
    logic last_q, last_d;
    logic half_q, half_d;
    logic edgePulse_q, edgePulse_d;
    logic level;
    logic rawEdge;

    // two flops per pin; only the second stage feeds any logic
    always_comb begin
        syncA_d = {syncA_q[0], pinIn[0]};
        syncB_d = {syncB_q[0], pinIn[1]};
    end

    // selection after synchronising, so switching never sees a metastable value
    always_comb begin
        level = pinSel ? syncB_q[1] : syncA_q[1];
        rawEdge = invert ? (last_q & ~level) : (~last_q & level);
        last_d = level;
        half_d = half_q;
        edgePulse_d = 1'b0;
        if (rawEdge) begin
            if (prescale) begin
                half_d = ~half_q;
                edgePulse_d = half_q;
            end else begin
                half_d = 1'b0;
                edgePulse_d = 1'b1;
            end
        end
    end

    // registers of the edge path
    always_ff @(posedge clk) begin
        if (!resetn) begin
            syncA_q <= 2'h0;
            syncB_q <= 2'h0;
            last_q <= 1'b0;
            half_q <= 1'b0;
            edgePulse_q <= 1'b0;
        end else begin
            syncA_q <= syncA_d;
            syncB_q <= syncB_d;
            last_q <= last_d;
            half_q <= half_d;
            edgePulse_q <= edgePulse_d;
        end
    end

    assign edgePulse = edgePulse_q;

endmodule

/* rtl/dpd_ratio_div.sv */
// edge counter dividing by programmed ratio plus one
`timescale 1ns/10ps
module dpd_ratio_div
    import dpd_pkg::*;
#(
    parameter int WIDTH = 16 // ratio register width
) (
    input wire logic clk, // system clock
    input wire logic resetn, // synchronous reset, active low
    input wire logic edgeIn, // one pulse per input edge
    input wire logic [WIDTH-1:0] ratio, // programmed value, divides by ratio+1
    output logic divPulse // one cycle per completed period
);

    logic [WIDTH-1:0] count_q, count_d;
    logic divPulse_q, divPulse_d;

    // count edges; >= lets a lowered ratio take effect without wrapping through 2^16
    always_comb begin
        count_d = count_q;
        divPulse_d = 1'b0;
        if (edgeIn) begin
            if (count_q >= ratio) begin
                count_d = '0;
                divPulse_d = 1'b1;
            end else begin
                count_d = count_q + 1'b1;
            end
        end
    end

    // counter registers
    always_ff @(posedge clk) begin
        if (!resetn) begin
            count_q <= '0;
            divPulse_q <= 1'b0;
        end else begin
            count_q <= count_d;
            divPulse_q <= divPulse_d;
        end
    end

    assign divPulse = divPulse_q;

endmodule

/* tb/dpd_dividers_chk.sv */
// port assertions for the divider block
`timescale 1ns/10ps
module dpd_dividers_chk
    import dpd_pkg::*;
#(
    parameter int RATIO_WIDTH = 16 // ratio width
) (
    input wire logic clk, // clock
    input wire logic resetn, // reset, active low
    input wire logic wb_cyc_i, // cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_we_i, // write enable
    input wire logic [11:0] wb_adr_i, // byte address
    input wire logic [31:0] wb_dat_o, // read data
    input wire logic wb_ack_o, // acknowledge
    input wire logic refDivPulse, // reference pulse
    input wire logic fbDivPulse // feedback pulse
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    // bus answers one cycle after a request is taken
    a_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
        else $error("ack without request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_data_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
        else $error("upper read data not zero");
    // reserved control bits read back as zero
    a_ctrl_reserved: assert property (wb_ack_o && !wb_we_i
        && (wb_adr_i[11:2] == REG_REF_DIVIDER_CONTROL
        || wb_adr_i[11:2] == REG_FEEDBACK_DIVIDER_CONTROL) |-> wb_dat_o[6:1] == 6'h00)
        else $error("reserved control bits set");
    a_reset_quiet: assert property ($rose(resetn) |-> !wb_ack_o && !refDivPulse && !fbDivPulse)
        else $error("outputs active after reset");
    // pin edges of one polarity are three or more cycles apart
    a_ref_gap: assert property (refDivPulse |=> !refDivPulse [*2])
        else $error("reference pulses too close");
    a_fb_gap: assert property (fbDivPulse |=> !fbDivPulse [*2])
        else $error("feedback pulses too close");
endmodule

bind dpd_dividers dpd_dividers_chk #(.RATIO_WIDTH(RATIO_WIDTH)) u_chk (.clk, .resetn, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .refDivPulse, .fbDivPulse);

/* tb/dpd_clk_src.sv */
// clock source model for the reference and feedback pins
`timescale 1ns/10ps
module dpd_clk_src #(
    parameter int HALF = 8 // half period in clk cycles
) (
    input wire logic clk, // bench clock
    input wire logic start, // begin a burst
    input wire logic [1:0] pinSel, // 0 ref a, 1 ref b, 2 feedback
    input wire logic [15:0] periods, // whole periods per burst
    output logic [2:0] pins, // feedback, ref b, ref a
    output logic busy // burst running
);
    int cnt = 0;
    initial pins = 3'h0;
    assign busy = cnt != 0;
    // whole periods from low, far below the rate that needs the prescaler
    always @(posedge clk) begin
        if (start && cnt == 0) begin
            cnt <= periods * 2 * HALF;
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
            if (cnt % HALF == 0) begin
                pins[pinSel] <= ~pins[pinSel];
            end
        end
    end
endmodule

/* tb/tb_dpd_dividers.sv */
// self-checking bench for the divider block
`timescale 1ns/10ps
module tb_dpd_dividers;
    import dpd_pkg::*;
    logic clk = 1'h0;
    logic resetn = 1'h0;
    logic cyc = 1'h0, stb = 1'h0, we = 1'h0, start = 1'h0, expPol = 1'h1;
    logic [11:0] adr = 12'h000;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat;
    logic ack, refPulse, fbPulse, busy;
    logic [1:0] pinSel = 2'h0;
    logic [15:0] periods = 16'h0;
    logic [2:0] pins;
    int errCount = 0, totalChecks = 0, nRef = 0, nFb = 0, r;

    always #2 clk = ~clk;

    dpd_dividers u_dut (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .referenceInputA(pins[0]), .referenceInputB(pins[1]),
        .feedbackClockInput(pins[2]), .refDivPulse(refPulse), .fbDivPulse(fbPulse));
    dpd_clk_src u_src (.clk(clk), .start(start), .pinSel(pinSel), .periods(periods),
        .pins(pins), .busy(busy));

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        totalChecks++;
        if (got !== exp) begin
            errCount++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic endOfTest();
        $display("checks %0d mismatches %0d", totalChecks, errCount);
        if (errCount == 0 && totalChecks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // pulses counted; pin level behind each shows which edge was counted
    always @(posedge clk) begin
        if (resetn && (refPulse || fbPulse)) begin
            nRef += refPulse;
            nFb += fbPulse;
            cmp("counted edge level", expPol, pins[pinSel]);
        end
    end

    // one classic cycle, held until ack is sampled high
    task automatic wbXfer(input logic [9:0] idx, input logic wr, input logic ln,
        input logic [7:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= wr;
        adr <= {idx, 2'h0};
        sel <= {3'($urandom), ln};
        wdat <= {24'($urandom), d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'h1 && n < 50);
        q = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
        if (ack !== 1'h1) begin
            errCount++;
            endOfTest();
        end
    endtask

    task automatic doReset();
        @(posedge clk);
        resetn <= 1'h0;
        repeat (10) @(posedge clk);
        resetn <= 1'h1;
        repeat (6) @(posedge clk);
        nRef = 0;
        nFb = 0;
    endtask

    // reset values, readback, lane 0 gating and an unmapped place
    task automatic regTest();
        logic [31:0] q;
        logic [9:0] idx;
        logic [7:0] v;
        doReset();
        for (int i = 0; i < 7; i++) begin
            idx = (i < 6) ? REG_REF_DIVIDER_LOW + 10'(i) : 10'h0FF;
            v = 8'($urandom);
            wbXfer(idx, 1'h0, 1'h1, 8'h00, q);
            cmp("reset value", 32'h0, q);
            wbXfer(idx, 1'h1, 1'h1, v, q);
            wbXfer(idx, 1'h1, 1'h0, ~v, q);
            wbXfer(idx, 1'h0, 1'h1, 8'h00, q);
            cmp("readback", (i == 6) ? 0 : (i % 3 == 2) ? v & CONTROL_MASK : v, q);
        end
        $display("register test done");
    endtask

    // program one path, run whole periods, compare pulse counts with the model
    task automatic runCase(input int path, input logic [15:0] ratio, input logic inv,
        input logic pre, input int nEdge);
        logic [31:0] q;
        logic [9:0] base;
        int n, exp;
        doReset();
        base = (path == 2) ? REG_FEEDBACK_DIVIDER_LOW : REG_REF_DIVIDER_LOW;
        wbXfer(base, 1'h1, 1'h1, ratio[7:0], q);
        wbXfer(base + 10'h1, 1'h1, 1'h1, ratio[15:8], q);
        wbXfer(base + 10'h2, 1'h1, 1'h1, {inv, 6'h3F, pre}, q);
        wbXfer(base + 10'h2, 1'h0, 1'h1, 8'h00, q);
        cmp("control", {24'h0, inv, 6'h00, pre}, q);
        wbXfer(REG_INPUT_SELECT_STATUS, 1'h1, 1'h1, {7'h00, path == 1}, q);
        pinSel <= 2'(path);
        expPol <= !inv;
        periods <= 16'(pre ? 2 * nEdge : nEdge);
        start <= 1'h1;
        @(posedge clk);
        start <= 1'h0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (busy && n < 20000);
        repeat (12) @(posedge clk);
        exp = (pre ? periods / 2 : periods) / (ratio + 1);
        cmp("ref pulses", (path != 2) ? exp : 0, nRef);
        cmp("fb pulses", (path == 2) ? exp : 0, nFb);
        // select readback and sticky pulse flags, then the flags cleared by that read
        wbXfer(REG_INPUT_SELECT_STATUS, 1'h0, 1'h1, 8'h00, q);
        cmp("status", {26'h0, path == 2 && exp > 0, path != 2 && exp > 0, 3'h0, path == 1}, q);
        wbXfer(REG_INPUT_SELECT_STATUS, 1'h0, 1'h1, 8'h00, q);
        cmp("status cleared", {31'h0, path == 1}, q);
        if (busy) begin
            errCount++;
            endOfTest();
        end
        $display("case done path %0d ratio %0d", path, ratio);
    endtask

    initial begin
        r = $urandom(22254);
        regTest();
        runCase(0, 16'h0000, 1'h0, 1'h0, 5 + $urandom_range(15));
        runCase(2, 16'h0000, 1'h0, 1'h0, 5 + $urandom_range(15));
        runCase(1, 16'h0100, 1'h0, 1'h0, 385);
        runCase(2, 16'h0100, 1'h0, 1'h0, 385);
        r = 2 + $urandom_range(4);
        runCase(0, 16'(r), 1'h1, 1'h1, 2 * (r + 1) + (r + 1) / 2);
        runCase(2, 16'(r), 1'h1, 1'h1, 2 * (r + 1) + (r + 1) / 2);
        runCase(1, 16'(r), 1'h0, 1'h1, 3 * (r + 1) + (r + 1) / 2);
        endOfTest();
    end
endmodule
